// file: rtl/retimer_cfg_pkg.sv
// constants shared by the retimer configuration and status logic
package retimer_cfg_pkg;

  // ==========================================================
  // channel count and register offsets
  localparam int         NUM_CH           = 4;
  localparam logic [7:0] OFS_CH_FLAGS     = 8'h05;
  localparam logic [7:0] OFS_CDR_BYPASS   = 8'h09;
  localparam logic [7:0] OFS_MUX_SEL      = 8'h1E;
  localparam logic [7:0] OFS_FALSE_LOCK   = 8'h2F;
  localparam logic [7:0] OFS_REF_MODE     = 8'h36;
  localparam logic [7:0] OFS_EYE_INT_EN   = 8'h6A;
  localparam logic [7:0] OFS_HEO_THRESH   = 8'h6B;
  localparam logic [7:0] OFS_VEO_THRESH   = 8'h6C;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h78;
  localparam logic [7:0] OFS_CHAN_SELECT  = 8'hFF;

  // ==========================================================
  // field positions
  localparam int CDR_BYPASS_BIT  = 5;
  localparam int MUX_SEL_LSB     = 5;
  localparam int FALSE_LOCK_BIT  = 1;
  localparam int REF_MODE_LSB    = 4;
  localparam int EYE_INT_EN_BIT  = 0;
  localparam int EV_LOS_BIT      = 0;
  localparam int EV_LOL_BIT      = 1;
  localparam int EV_EYE_BIT      = 2;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0] RST_CDR_BYPASS = 8'h00;
  localparam logic [7:0] RST_MUX_SEL    = 8'h00;
  localparam logic [7:0] RST_FALSE_LOCK = 8'h02;
  localparam logic [7:0] RST_REF_MODE   = 8'h30;
  localparam logic [7:0] RST_EYE_INT_EN = 8'h00;
  localparam logic [7:0] RST_THRESH     = 8'h00;
  localparam logic [1:0] REF_MODE_NONE  = 2'h0;
  localparam logic [6:0] ADDR7_BASE     = 7'h18;
  localparam logic [6:0] ADDR7_TEST     = 7'h18;
  localparam logic [6:0] EE_ADDR7       = 7'h50;
  localparam logic [7:0] EE_START_OFS   = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_MHZ     = 100;
  localparam int SMB_QUARTER_NS   = 2500;
  localparam int SMB_QUARTER_CYC  =
    (SMB_QUARTER_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int QW               = $clog2(SMB_QUARTER_CYC);
  localparam int STRAP_SETTLE_CYC = 3;

endpackage

// file: rtl/smbus_target_port.sv
// byte-level smbus target with register pointer and auto-increment
`timescale 1ns/1ns
`default_nettype none

module smbus_target_port (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] rd_data,
  output logic      [7:0] rd_addr,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic      [7:0] acc_addr,
  output logic      [7:0] wr_data
);

  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_ACK, T_WBYTE, T_RBYTE, T_RACK
  } tstate_t;

  typedef struct packed {
    tstate_t    st;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       have_ptr;
    logic [7:0] ptr;
    logic [7:0] ra;
    logic [7:0] wd;
    logic       oe;
    logic       wr;
    logic       rd;
  } tgt_t;

  tgt_t r_reg;
  tgt_t r_next;
  logic rise;
  logic fall;

  assign rd_addr  = r_reg.ptr;
  assign sda_oe   = r_reg.oe;
  assign wr_stb   = r_reg.wr;
  assign rd_stb   = r_reg.rd;
  assign acc_addr = r_reg.ra;
  assign wr_data  = r_reg.wd;

  always_comb begin
    r_next = r_reg;
    r_next.wr = 1'b0;
    r_next.rd = 1'b0;
    r_next.scl_q = scl;
    r_next.sda_q = sda;
    rise = scl & ~r_reg.scl_q;
    fall = ~scl & r_reg.scl_q;
    if (!enable) begin
      r_next.st = T_IDLE;
      r_next.oe = 1'b0;
    end else if (scl && r_reg.scl_q && r_reg.sda_q && !sda) begin
      r_next.st = T_ADDR;
      r_next.cnt = 4'h0;
      r_next.oe = 1'b0;
      r_next.have_ptr = 1'b0;
    end else if (scl && r_reg.scl_q && !r_reg.sda_q && sda) begin
      r_next.st = T_IDLE;
      r_next.oe = 1'b0;
    end else begin
      case (r_reg.st)
        T_ADDR, T_WBYTE: begin
          if (rise) begin
            r_next.sh = {r_reg.sh[6:0], sda};
            r_next.cnt = r_reg.cnt + 4'h1;
          end
          if (fall && r_reg.cnt == 4'h8) begin
            r_next.cnt = 4'h0;
            r_next.st = T_ACK;
            r_next.oe = 1'b1;
            if (r_reg.st == T_ADDR) begin
              r_next.rw = r_reg.sh[0];
              if (r_reg.sh[7:1] != dev_addr) begin
                r_next.st = T_IDLE;
                r_next.oe = 1'b0;
              end
            end else if (r_reg.have_ptr) begin
              r_next.wr = 1'b1;
              r_next.ra = r_reg.ptr;
              r_next.wd = r_reg.sh;
              r_next.ptr = r_reg.ptr + 8'h01;
            end else begin
              r_next.ptr = r_reg.sh;
              r_next.have_ptr = 1'b1;
            end
          end
        end
        T_ACK: begin
          if (fall) begin
            r_next.oe = 1'b0;
            r_next.st = T_WBYTE;
            if (r_reg.rw) begin
              r_next.sh = rd_data;
              r_next.oe = ~rd_data[7];
              r_next.rd = 1'b1;
              r_next.ra = r_reg.ptr;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.cnt = 4'h1;
              r_next.st = T_RBYTE;
            end
          end
        end
        T_RBYTE: begin
          if (fall) begin
            r_next.cnt = r_reg.cnt + 4'h1;
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.oe = ~r_reg.sh[6];
            if (r_reg.cnt == 4'h8) begin
              r_next.oe = 1'b0;
              r_next.st = T_RACK;
            end
          end
        end
        T_RACK: begin
          if (rise) begin
            r_next.st = sda ? T_IDLE : T_ACK;
          end
        end
        default: begin
          r_next.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

`default_nettype wire

// file: rtl/retimer_config_and_status.sv
// power-up configuration, reference mode and status logic of the retimer
`timescale 1ns/1ns
`default_nettype none

module retimer_config_and_status #(
  parameter int         EE_PAIRS = 16,
  parameter logic [6:0] EE_ADDR7 = retimer_cfg_pkg::EE_ADDR7
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ref_clock_input,
  output logic             ref_clock_forward_output,
  input  wire logic        config_mode_strap,
  input  wire logic        load_request_n,
  output logic             load_done_n,
  input  wire logic [3:0]  strap_lock_in,
  output logic      [3:0]  strap_lock_out,
  output logic      [3:0]  strap_lock_oe,
  input  wire logic        smb_scl_in,
  output logic             smb_scl_out,
  output logic             smb_scl_oe,
  input  wire logic        smb_sda_in,
  output logic             smb_sda_out,
  output logic             smb_sda_oe,
  output logic             int_n_out,
  output logic             int_n_oe,
  input  wire logic [3:0]  chan_signal_detect,
  input  wire logic [3:0]  chan_cdr_lock,
  input  wire logic [31:0] eye_opening_metrics_horiz,
  input  wire logic [31:0] eye_opening_metrics_vert,
  output logic      [7:0]  chan_ref_mode,
  output logic      [3:0]  chan_ref_assist,
  output logic      [3:0]  chan_false_lock_en,
  output logic      [3:0]  chan_cdr_bypass,
  output logic      [11:0] chan_mux_sel
);

  typedef enum logic [2:0] {
    P_INIT, P_WAIT, P_START, P_BYTE, P_STOP, P_SLAVE
  } phase_t;

  typedef struct packed {
    phase_t                   ph;
    logic [1:0]               scl_s;
    logic [1:0]               sda_s;
    logic [1:0]               ref_s;
    logic [1:0]               mode_s;
    logic [1:0]               req_s;
    logic [1:0][3:0]          strap_s;
    logic [1:0][3:0]          sd_s;
    logic [1:0][3:0]          lk_s;
    logic [1:0][31:0]         heo_s;
    logic [1:0][31:0]         veo_s;
    logic [3:0]               sd_q;
    logic [3:0]               lk_q;
    logic [retimer_cfg_pkg::QW-1:0] tcnt;
    logic [6:0]               addr7;
    logic [1:0]               qph;
    logic [3:0]               bitn;
    logic [7:0]               msh;
    logic [5:0]               mbyte;
    logic [7:0]               ee_off;
    logic                     scl_oe;
    logic                     sda_oe;
    logic                     m_sda;
    logic                     done_n;
    logic                     ref_out;
    logic [3:0]               lock_out;
    logic [3:0]               lock_oe;
    logic                     int_oe;
    logic [3:0]               assist;
    logic [3:0]               fle;
    logic [1:0]               chsel;
    logic [3:0][7:0]          cdr;
    logic [3:0][7:0]          mux;
    logic [3:0][7:0]          fld;
    logic [3:0][7:0]          refm;
    logic [3:0][7:0]          eyen;
    logic [3:0][7:0]          heot;
    logic [3:0][7:0]          veot;
    logic [3:0][7:0]          evs;
  } st_t;

  st_t        r_reg;
  st_t        r_next;
  logic       tick;
  logic       rx;
  logic       s_wr;
  logic       s_rd;
  logic       s_oe;
  logic [7:0] s_acc;
  logic [7:0] s_wdata;
  logic [7:0] s_rd_addr;
  logic [7:0] s_rdata;

  // ==========================================================
  // register access
  function automatic st_t reg_write(st_t s, logic [7:0] a, logic [7:0] d);
    st_t t;
    t = s;
    case (a)
      retimer_cfg_pkg::OFS_CDR_BYPASS:  t.cdr[s.chsel] = d;
      retimer_cfg_pkg::OFS_MUX_SEL:     t.mux[s.chsel] = d;
      retimer_cfg_pkg::OFS_FALSE_LOCK:  t.fld[s.chsel] = d;
      retimer_cfg_pkg::OFS_REF_MODE:    t.refm[s.chsel] = d;
      retimer_cfg_pkg::OFS_EYE_INT_EN:  t.eyen[s.chsel] = d;
      retimer_cfg_pkg::OFS_HEO_THRESH:  t.heot[s.chsel] = d;
      retimer_cfg_pkg::OFS_VEO_THRESH:  t.veot[s.chsel] = d;
      retimer_cfg_pkg::OFS_CHAN_SELECT: t.chsel = d[1:0];
      default: ;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] reg_read(st_t s, logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      retimer_cfg_pkg::OFS_CH_FLAGS: begin
        for (int c = 0; c < retimer_cfg_pkg::NUM_CH; c++) begin
          v[c] = |s.evs[c];
        end
      end
      retimer_cfg_pkg::OFS_CDR_BYPASS:   v = s.cdr[s.chsel];
      retimer_cfg_pkg::OFS_MUX_SEL:      v = s.mux[s.chsel];
      retimer_cfg_pkg::OFS_FALSE_LOCK:   v = s.fld[s.chsel];
      retimer_cfg_pkg::OFS_REF_MODE:     v = s.refm[s.chsel];
      retimer_cfg_pkg::OFS_EYE_INT_EN:   v = s.eyen[s.chsel];
      retimer_cfg_pkg::OFS_HEO_THRESH:   v = s.heot[s.chsel];
      retimer_cfg_pkg::OFS_VEO_THRESH:   v = s.veot[s.chsel];
      retimer_cfg_pkg::OFS_EVENT_STATUS: v = s.evs[s.chsel];
      retimer_cfg_pkg::OFS_CHAN_SELECT:  v = {6'h00, s.chsel};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // bytes sent before the eeprom data: write, offset, read
  function automatic logic [7:0] ee_tx_byte(logic [5:0] idx);
    logic [7:0] b;
    b = {EE_ADDR7, 1'b1};
    if (idx == 6'h00) begin
      b = {EE_ADDR7, 1'b0};
    end else if (idx == 6'h01) begin
      b = retimer_cfg_pkg::EE_START_OFS;
    end
    return b;
  endfunction

  assign s_rdata = reg_read(r_reg, s_rd_addr);

  smbus_target_port u_target (
    .clock    (clock),
    .rst      (rst),
    .enable   (r_reg.ph == P_SLAVE),
    .scl      (r_reg.scl_s[1]),
    .sda      (r_reg.sda_s[1]),
    .dev_addr (r_reg.addr7),
    .rd_data  (s_rdata),
    .rd_addr  (s_rd_addr),
    .sda_oe   (s_oe),
    .wr_stb   (s_wr),
    .rd_stb   (s_rd),
    .acc_addr (s_acc),
    .wr_data  (s_wdata)
  );

  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    tick = (r_reg.tcnt == retimer_cfg_pkg::QW'(
            retimer_cfg_pkg::SMB_QUARTER_CYC - 1));
    rx = (r_reg.mbyte >= 6'h03);
    r_next.tcnt = tick ? '0 : r_reg.tcnt + 1'b1;
    r_next.scl_s = {r_reg.scl_s[0], smb_scl_in};
    r_next.sda_s = {r_reg.sda_s[0], smb_sda_in};
    r_next.ref_s = {r_reg.ref_s[0], ref_clock_input};
    r_next.mode_s = {r_reg.mode_s[0], config_mode_strap};
    r_next.req_s = {r_reg.req_s[0], load_request_n};
    r_next.strap_s = {r_reg.strap_s[0], strap_lock_in};
    r_next.sd_s = {r_reg.sd_s[0], chan_signal_detect};
    r_next.lk_s = {r_reg.lk_s[0], chan_cdr_lock};
    r_next.heo_s = {r_reg.heo_s[0], eye_opening_metrics_horiz};
    r_next.veo_s = {r_reg.veo_s[0], eye_opening_metrics_vert};
    r_next.sd_q = r_reg.sd_s[1];
    r_next.lk_q = r_reg.lk_s[1];
    r_next.ref_out = r_reg.ref_s[1];
    r_next.lock_out = r_reg.lk_s[1];

    case (r_reg.ph)
      P_INIT: begin
        if (r_reg.tcnt == retimer_cfg_pkg::QW'(
            retimer_cfg_pkg::STRAP_SETTLE_CYC)) begin
          r_next.addr7 = retimer_cfg_pkg::ADDR7_BASE +
                         {3'h0, r_reg.strap_s[1]};
          if (r_reg.mode_s[1] && r_reg.req_s[1]) begin
            r_next.addr7 = retimer_cfg_pkg::ADDR7_TEST;
          end
          r_next.lock_oe = 4'hF;
          r_next.ph = r_reg.mode_s[1] ? P_SLAVE : P_WAIT;
          r_next.done_n = ~r_reg.mode_s[1];
        end
      end
      P_WAIT: begin
        if (!r_reg.req_s[1] && tick) begin
          r_next.ph = P_START;
          r_next.qph = 2'h0;
          r_next.mbyte = 6'h00;
        end
      end
      P_START: begin
        if (tick) begin
          r_next.qph = r_reg.qph + 2'h1;
          case (r_reg.qph)
            2'h0: begin
              r_next.m_sda = 1'b0;
              r_next.scl_oe = 1'b0;
            end
            2'h1: r_next.m_sda = 1'b1;
            default: begin
              r_next.scl_oe = 1'b1;
              r_next.ph = P_BYTE;
              r_next.qph = 2'h0;
              r_next.bitn = 4'h0;
              r_next.msh = ee_tx_byte(r_reg.mbyte);
            end
          endcase
        end
      end
      P_BYTE: begin
        if (tick) begin
          r_next.qph = r_reg.qph + 2'h1;
          case (r_reg.qph)
            2'h0: begin
              if (r_reg.bitn != 4'h8) begin
                r_next.m_sda = rx ? 1'b0 : ~r_reg.msh[7];
              end else begin
                r_next.m_sda = rx && (r_reg.mbyte !=
                               6'(2 + 2 * EE_PAIRS));
              end
            end
            2'h1: r_next.scl_oe = 1'b0;
            2'h2: begin
              if (r_reg.bitn != 4'h8) begin
                r_next.msh = rx ? {r_reg.msh[6:0], r_reg.sda_s[1]}
                                : {r_reg.msh[6:0], 1'b0};
              end
            end
            default: begin
              r_next.scl_oe = 1'b1;
              r_next.bitn = r_reg.bitn + 4'h1;
              if (r_reg.bitn == 4'h8) begin
                r_next.bitn = 4'h0;
                r_next.mbyte = r_reg.mbyte + 6'h01;
                r_next.msh = ee_tx_byte(r_reg.mbyte + 6'h01);
                if (rx && r_reg.mbyte[0]) begin
                  r_next.ee_off = r_reg.msh;
                end else if (rx) begin
                  r_next = reg_write(r_next, r_reg.ee_off, r_reg.msh);
                end
                if (r_reg.mbyte == 6'h01) begin
                  r_next.ph = P_START;
                end else if (r_reg.mbyte == 6'(2 + 2 * EE_PAIRS)) begin
                  r_next.ph = P_STOP;
                end
                // nack acted on with scl low, so the stop stays clean
                if (!rx && r_reg.sda_s[1]) begin
                  r_next.ph = P_STOP;
                end
              end
            end
          endcase
        end
      end
      P_STOP: begin
        if (tick) begin
          r_next.qph = r_reg.qph + 2'h1;
          case (r_reg.qph)
            2'h0: r_next.m_sda = 1'b1;
            2'h1: r_next.scl_oe = 1'b0;
            default: begin
              r_next.m_sda = 1'b0;
              r_next.ph = P_SLAVE;
              r_next.done_n = 1'b0;
            end
          endcase
        end
      end
      P_SLAVE: begin
        r_next.scl_oe = 1'b0;
        if (s_wr) begin
          r_next = reg_write(r_next, s_acc, s_wdata);
        end
        if (s_rd && s_acc == retimer_cfg_pkg::OFS_EVENT_STATUS) begin
          r_next.evs[r_reg.chsel] = 8'h00;
        end
      end
      default: r_next.ph = P_INIT;
    endcase

    // master owns sda only while it holds the bus
    r_next.sda_oe = (r_reg.ph == P_SLAVE) ? s_oe : r_reg.m_sda;

    // events set after clears so a coincident event survives
    for (int c = 0; c < retimer_cfg_pkg::NUM_CH; c++) begin
      if (r_reg.sd_q[c] && !r_reg.sd_s[1][c]) begin
        r_next.evs[c][retimer_cfg_pkg::EV_LOS_BIT] = 1'b1;
      end
      if (r_reg.lk_q[c] && !r_reg.lk_s[1][c]) begin
        r_next.evs[c][retimer_cfg_pkg::EV_LOL_BIT] = 1'b1;
      end
      if (r_reg.eyen[c][retimer_cfg_pkg::EYE_INT_EN_BIT] &&
          r_reg.lk_s[1][c] &&
          (r_reg.heo_s[1][c*8 +: 8] < r_reg.heot[c] ||
           r_reg.veo_s[1][c*8 +: 8] < r_reg.veot[c])) begin
        r_next.evs[c][retimer_cfg_pkg::EV_EYE_BIT] = 1'b1;
      end
      r_next.assist[c] = r_next.refm[c][retimer_cfg_pkg::REF_MODE_LSB +: 2]
                         != retimer_cfg_pkg::REF_MODE_NONE;
      r_next.fle[c] =
        ~r_next.fld[c][retimer_cfg_pkg::FALSE_LOCK_BIT];
    end
    r_next.int_oe = |r_next.evs;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.done_n <= 1'b1;
      r_reg.cdr <= {4{retimer_cfg_pkg::RST_CDR_BYPASS}};
      r_reg.mux <= {4{retimer_cfg_pkg::RST_MUX_SEL}};
      r_reg.fld <= {4{retimer_cfg_pkg::RST_FALSE_LOCK}};
      r_reg.refm <= {4{retimer_cfg_pkg::RST_REF_MODE}};
      r_reg.eyen <= {4{retimer_cfg_pkg::RST_EYE_INT_EN}};
      r_reg.heot <= {4{retimer_cfg_pkg::RST_THRESH}};
      r_reg.veot <= {4{retimer_cfg_pkg::RST_THRESH}};
      r_reg.assist <= 4'hF;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign ref_clock_forward_output = r_reg.ref_out;
  assign load_done_n   = r_reg.done_n;
  assign strap_lock_out = r_reg.lock_out;
  assign strap_lock_oe  = r_reg.lock_oe;
  assign smb_scl_out   = 1'b0;
  assign smb_scl_oe    = r_reg.scl_oe;
  assign smb_sda_out   = 1'b0;
  assign smb_sda_oe    = r_reg.sda_oe;
  assign int_n_out     = 1'b0;
  assign int_n_oe      = r_reg.int_oe;
  assign chan_ref_assist    = r_reg.assist;
  assign chan_false_lock_en = r_reg.fle;

  generate
    for (genvar c = 0; c < 4; c++) begin : g_ch
      assign chan_ref_mode[c*2 +: 2] =
        r_reg.refm[c][retimer_cfg_pkg::REF_MODE_LSB +: 2];
      assign chan_cdr_bypass[c] =
        r_reg.cdr[c][retimer_cfg_pkg::CDR_BYPASS_BIT];
      assign chan_mux_sel[c*3 +: 3] =
        r_reg.mux[c][retimer_cfg_pkg::MUX_SEL_LSB +: 3];
    end
  endgenerate

endmodule

`default_nettype wire

// file: sim/retimer_cfg_props.sv
// port assertions for the retimer configuration and status block
`timescale 1ns/1ns
`default_nettype none
module retimer_cfg_props (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ref_clock_input,
  input wire logic       ref_clock_forward_output,
  input wire logic       load_request_n,
  input wire logic       load_done_n,
  input wire logic [3:0] strap_lock_oe,
  input wire logic [3:0] strap_lock_out,
  input wire logic [3:0] chan_cdr_lock,
  input wire logic [3:0] chan_signal_detect,
  input wire logic       smb_scl_oe,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  input wire logic [7:0] chan_ref_mode,
  input wire logic [3:0] chan_ref_assist,
  input wire logic [3:0] chan_false_lock_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // sequences and checks
  sequence s_unlatched;
    (strap_lock_oe == 4'h0) [*2];
  endsequence
  a_lock_pins_late:
    assert property ($fell(rst) |-> s_unlatched ##[1:6] strap_lock_oe == 4'hF)
      else $error("lock pins not handed over after strap latch");
  a_pins_held:
    assert property (strap_lock_oe == 4'hF |=> strap_lock_oe == 4'hF)
      else $error("lock pins dropped");
  a_lock_follow:
    assert property ((strap_lock_oe == 4'hF && $stable(chan_cdr_lock)) [*4]
      |-> strap_lock_out == chan_cdr_lock) else $error("lock pin wrong");
  a_ref_rise:
    assert property ($rose(ref_clock_input) |->
      ##[2:3] ref_clock_forward_output)
      else $error("reference copy missed a rise");
  a_ref_fall:
    assert property ($fell(ref_clock_input) |->
      ##[2:3] !ref_clock_forward_output)
      else $error("reference copy missed a fall");
  a_reset_modes:
    assert property ($fell(rst) |-> chan_ref_mode == 8'hFF
      && chan_false_lock_en == 4'h0) else $error("mode reset value wrong");
  a_assist_mode:
    assert property ($stable(chan_ref_mode) [*2] |->
      chan_ref_assist[0] == (chan_ref_mode[1:0] != 2'h0))
      else $error("reference assist disagrees with mode");
  a_int_drain:
    assert property (int_n_out == 1'b0) else $error("interrupt pin drives high");
  a_int_los:
    assert property ($fell(chan_signal_detect[0]) |-> ##[1:8] int_n_oe)
      else $error("no interrupt on signal loss");
  a_int_lol:
    assert property ($fell(chan_cdr_lock[0]) |-> ##[1:8] int_n_oe)
      else $error("no interrupt on lock loss");
  a_quiet_bus:
    assert property ((load_request_n && load_done_n) [*4] |-> !smb_scl_oe)
      else $error("bus driven without load request");
  a_done_held:
    assert property (!load_done_n |=> !load_done_n)
      else $error("load complete released");
endmodule
bind retimer_config_and_status retimer_cfg_props u_props (.clock, .rst,
  .ref_clock_input, .ref_clock_forward_output, .load_request_n,
  .load_done_n, .strap_lock_oe, .strap_lock_out, .chan_cdr_lock,
  .chan_signal_detect, .smb_scl_oe, .int_n_out, .int_n_oe, .chan_ref_mode,
  .chan_ref_assist, .chan_false_lock_en);
`default_nettype wire

// file: sim/smb_partner.sv
// smbus controller model on a pulled-up open-drain pair
`timescale 1ns/1ns
`default_nettype none
module smb_partner #(
  parameter int HALF = 8
) (
  input  wire logic clock,
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  output wire logic scl,
  output wire logic sda
);
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  logic nak_seen = 1'b0;
  assign scl = ~(scl_pull | dev_scl_oe);
  assign sda = ~(sda_pull | dev_sda_oe);
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // bit period is two halves; sda moves mid-low only
  task automatic put_bit(input logic b, output logic r);
    sda_pull <= ~b;
    w(HALF / 2);
    scl_pull <= 1'b0;
    w(HALF - 1);
    @(negedge clock);
    r = sda;
    @(posedge clock);
    scl_pull <= 1'b1;
    w(HALF / 2);
  endtask
  // ack bit always released; chk marks a byte the target must ack
  task automatic put_byte(input logic [7:0] tx, input logic chk,
                          output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(1'b1, a);
    if (chk && a) nak_seen = 1'b1;
  endtask
  task automatic start;
    sda_pull <= 1'b0;
    w(HALF);
    scl_pull <= 1'b0;
    w(HALF);
    sda_pull <= 1'b1;
    w(HALF);
    scl_pull <= 1'b1;
    w(HALF / 2);
  endtask
  task automatic stop;
    sda_pull <= 1'b1;
    w(HALF);
    scl_pull <= 1'b0;
    w(HALF);
    sda_pull <= 1'b0;
    w(HALF);
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// register-level testbench for the retimer configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [6:0] A = retimer_cfg_pkg::ADDR7_TEST;
  logic        clock;
  logic        rst;
  logic        ref_in;
  logic        mode;
  logic        req_n;
  logic [3:0]  straps;
  logic [3:0]  sig_det;
  logic [3:0]  cdr_lock;
  wire         scl;
  wire         sda;
  logic        scl_oe;
  logic        sda_oe;
  logic        done_n;
  logic        int_oe;
  logic [3:0]  lock_out;
  logic [3:0]  lock_oe;
  logic [7:0]  ref_mode;
  logic [3:0]  assist;
  logic [3:0]  fl_en;
  logic [3:0]  bypass;
  logic [11:0] mux;
  logic [7:0]  d;
  int          n_mismatch = 0;
  int          total_checks = 0;
  retimer_config_and_status #(.EE_PAIRS(1)) dut (.clock(clock), .rst(rst),
    .ref_clock_input(ref_in), .ref_clock_forward_output(),
    .config_mode_strap(mode), .load_request_n(req_n), .load_done_n(done_n),
    .strap_lock_in(straps), .strap_lock_out(lock_out),
    .strap_lock_oe(lock_oe), .smb_scl_in(scl), .smb_scl_out(),
    .smb_scl_oe(scl_oe), .smb_sda_in(sda), .smb_sda_out(),
    .smb_sda_oe(sda_oe), .int_n_out(), .int_n_oe(int_oe),
    .chan_signal_detect(sig_det), .chan_cdr_lock(cdr_lock),
    .eye_opening_metrics_horiz(32'h10101010),
    .eye_opening_metrics_vert(32'hFFFFFFFF), .chan_ref_mode(ref_mode),
    .chan_ref_assist(assist), .chan_false_lock_en(fl_en),
    .chan_cdr_bypass(bypass), .chan_mux_sel(mux));
  smb_partner p (.clock(clock), .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe),
    .scl(scl), .sda(sda));
  // ==========================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o,
                    input logic [7:0] v);
    logic [7:0] x;
    p.start();
    p.put_byte({a, 1'b0}, 1'b1, x);
    p.put_byte(o, 1'b1, x);
    p.put_byte(v, 1'b1, x);
    p.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] o);
    logic [7:0] x;
    p.start();
    p.put_byte({a, 1'b0}, 1'b1, x);
    p.put_byte(o, 1'b1, x);
    p.start();
    p.put_byte({a, 1'b1}, 1'b1, x);
    p.put_byte(8'hFF, 1'b0, d);
    p.stop();
  endtask
  task automatic power_up(input logic m, input logic [3:0] s);
    rst <= 1'b1;
    mode <= m;
    straps <= s;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (30) @(posedge clock);
  endtask
  // ==========================================================
  // clocks, watchdog and tests
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    ref_in = 1'b0;
    forever #20 ref_in = ~ref_in;
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    results();
  end
  initial begin
    {rst, mode, req_n, straps, sig_det, cdr_lock} = {3'b101, 4'h5, 8'hFF};
    power_up(1'b0, 4'h5);
    repeat (300) @(posedge clock);
    check(done_n, 1'b1);
    req_n <= 1'b0;
    for (int i = 0; i < 20000 && done_n !== 1'b0; i++) @(posedge clock);
    check(done_n, 1'b0);
    rd(retimer_cfg_pkg::ADDR7_BASE + 7'h5, retimer_cfg_pkg::OFS_REF_MODE);
    check(d, 8'h30);
    req_n <= 1'b1;
    power_up(1'b1, 4'hA);
    check(lock_oe, 4'hF);
    rd(7'h22, retimer_cfg_pkg::OFS_REF_MODE);
    check(p.nak_seen, 1'b1);
    p.nak_seen = 1'b0;
    rd(A, retimer_cfg_pkg::OFS_FALSE_LOCK);
    check(d, retimer_cfg_pkg::RST_FALSE_LOCK);
    wr(A, retimer_cfg_pkg::OFS_REF_MODE, 8'h00);
    check({assist[0], ref_mode[1:0]}, 3'h0);
    wr(A, retimer_cfg_pkg::OFS_FALSE_LOCK, 8'h00);
    check(fl_en[0], 1'b1);
    wr(A, retimer_cfg_pkg::OFS_CDR_BYPASS, 8'h20);
    wr(A, retimer_cfg_pkg::OFS_MUX_SEL, 8'hE0);
    check({bypass[0], mux[2:0]}, 4'hF);
    wr(A, retimer_cfg_pkg::OFS_MUX_SEL, 8'h00);
    check(mux[2:0], 3'h0);
    cdr_lock <= 4'hE;
    repeat (10) @(posedge clock);
    check({int_oe, lock_out}, 5'h1E);
    rd(A, retimer_cfg_pkg::OFS_EVENT_STATUS);
    check(d, 8'h02);
    check(int_oe, 1'b0);
    sig_det <= 4'hE;
    cdr_lock <= 4'hF;
    repeat (10) @(posedge clock);
    rd(A, retimer_cfg_pkg::OFS_EVENT_STATUS);
    check(d, 8'h01);
    wr(A, retimer_cfg_pkg::OFS_HEO_THRESH, 8'h80);
    check(int_oe, 1'b0);
    wr(A, retimer_cfg_pkg::OFS_EYE_INT_EN, 8'h01);
    check({int_oe, p.nak_seen}, 2'b10);
    rd(A, retimer_cfg_pkg::OFS_CH_FLAGS);
    check(d, 8'h01);
    wr(A, retimer_cfg_pkg::OFS_CHAN_SELECT, 8'h01);
    wr(A, retimer_cfg_pkg::OFS_REF_MODE, 8'h00);
    check(ref_mode, 8'hF0);
    check(assist, 4'hC);
    results();
  end
endmodule
`default_nettype wire
